// file: common/psyn_pkg.sv
// Purpose: Shared constants and types for the synthesizer digital core.
// Assumes: core clock of 10 MHz; serial words of 24 bits, MSB first.
// Notes: Field positions are bit indices within the transferred word.
package psyn_pkg;

  // Word and counter widths
  localparam int WORD_W = 24;
  localparam int R_W = 14;
  localparam int B_W = 13;
  localparam int A_W = 6;
  localparam int P_W = 7;
  localparam int ERR_W = 8;
  localparam int RUN_W = 3;

  // Destination select codes in the two low bits
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_FB = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;

  // Field positions
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 1;
  localparam int R_LSB = 2;
  localparam int R_MSB = 15;
  localparam int ABW_LSB = 16;
  localparam int ABW_MSB = 17;
  localparam int PREC_BIT = 20;
  localparam int A_LSB = 2;
  localparam int A_MSB = 7;
  localparam int B_LSB = 8;
  localparam int B_MSB = 20;
  localparam int CLR_BIT = 2;
  localparam int OUTSEL_LSB = 4;
  localparam int OUTSEL_MSB = 6;
  localparam int MOD_LSB = 22;
  localparam int MOD_MSB = 23;

  // Reset values of the active settings
  localparam logic [R_W-1:0] R_RST = 14'h0001;
  localparam logic [B_W-1:0] B_RST = 13'h0003;
  localparam logic [A_W-1:0] A_RST = 6'h00;
  localparam logic [2:0] OUTSEL_RST = 3'h0;
  localparam logic [1:0] MOD_RST = 2'h0;
  localparam logic [1:0] ABW_RST = 2'h0;

  // Prescaler moduli, smallest first
  localparam logic [P_W-1:0] PMOD0 = 7'h08;
  localparam logic [P_W-1:0] PMOD1 = 7'h10;
  localparam logic [P_W-1:0] PMOD2 = 7'h20;
  localparam logic [P_W-1:0] PMOD3 = 7'h40;

  // Antibacklash widths in core cycles, code 1 is the minimum
  localparam logic [1:0] ABW_CYC0 = 2'h2;
  localparam logic [1:0] ABW_CYC1 = 2'h1;
  localparam logic [1:0] ABW_CYC2 = 2'h3;
  localparam logic [1:0] ABW_CYC3 = 2'h2;

  // Output select codes
  localparam logic [2:0] OUT_TRI = 3'h0;
  localparam logic [2:0] OUT_DLOCK = 3'h1;
  localparam logic [2:0] OUT_NDIV = 3'h2;
  localparam logic [2:0] OUT_HIGH = 3'h3;
  localparam logic [2:0] OUT_RDIV = 3'h4;
  localparam logic [2:0] OUT_ALOCK = 3'h5;
  localparam logic [2:0] OUT_LOW = 3'h7;

  // Lock timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LOCK_NS = 15;
  localparam int UNLOCK_NS = 25;
  localparam int LOCK_RAW = LOCK_NS / CLK_PERIOD_NS;
  localparam int UNLOCK_RAW = (UNLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [ERR_W-1:0] LOCK_CYC = ERR_W'((LOCK_RAW < 1) ? 1 : LOCK_RAW);
  localparam logic [ERR_W-1:0] UNLOCK_CYC = ERR_W'((UNLOCK_RAW < 1) ? 1 : UNLOCK_RAW);
  localparam logic [RUN_W-1:0] RUN_SHORT = 3'h3;
  localparam logic [RUN_W-1:0] RUN_LONG = 3'h5;

  typedef enum logic [1:0] {
    PFD_IDLE = 2'b00,
    PFD_UP = 2'b01,
    PFD_DN = 2'b10,
    PFD_BOTH = 2'b11
  } psyn_pfd_t;

endpackage

// file: src/psyn_div.sv
// Purpose: Programmable divider, one pulse per ratio ticks.
// Assumes: tick is a one-cycle pulse on core_clk; ratio zero acts as one.
// Notes: Clear holds the count at its load point.
`timescale 1ns/100ps
module psyn_div #(
  parameter int W = 14
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick,
  input wire logic [W-1:0] ratio,
  output logic pulse
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_pulse;
  logic [W:0] count_inc;

  // Wrap after ratio ticks; wide compare avoids overflow at full scale
  always_comb
  begin
    count_inc = {1'b0, count} + {{W{1'b0}}, 1'b1};
    next_count = count;
    next_pulse = 1'b0;
    if (clear)
    begin
      next_count = '0;
    end
    else if (tick)
    begin
      if (count_inc >= {1'b0, ratio})
      begin
        next_count = '0;
        next_pulse = 1'b1;
      end
      else
      begin
        next_count = count_inc[W-1:0];
      end
    end
  end

  // Register stage
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      count <= '0;
      pulse <= 1'b0;
    end
    else
    begin
      count <= next_count;
      pulse <= next_pulse;
    end
  end

  property p_pulse_cause;
    @(posedge core_clk) disable iff (!rst_n)
    pulse |-> $past(tick) && !$past(clear);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("divider pulse without tick");

endmodule // psyn_div

// file: src/psyn_core.sv
// Purpose: Digital core of a frequency synthesizer: serial load, dividers, detector, lock, output mux.
// Assumes: serial data is stable at serial_clk rising edges; word held stable while strobe is high.
// Notes: ref_in and rf_in are edge sampled on core_clk, so their rates must stay well below it.
`timescale 1ns/100ps
module psyn_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic word_transfer_strobe,
  input wire logic ref_in,
  input wire logic rf_in,
  output logic pump_up,
  output logic pump_dn,
  output logic dig_lock,
  output logic multiplexed_status_pin,
  output logic multiplexed_status_pin_oe
);
  import psyn_pkg::*;

  logic [WORD_W-1:0] shreg;
  logic [WORD_W-1:0] next_shreg;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;
  logic load;
  logic ref_edge;
  logic rf_edge;
  logic [1:0] sel;
  logic [R_W-1:0] r_ratio, next_r_ratio;
  logic [1:0] abw_sel, next_abw_sel;
  logic lock_precision_select, next_lock_precision_select;
  logic [A_W-1:0] a_val, next_a_val;
  logic [B_W-1:0] b_val, next_b_val;
  logic [2:0] outsel, next_outsel;
  logic counter_clear_bit, next_counter_clear_bit;
  logic [1:0] mod_sel, next_mod_sel;
  logic arm_first, next_arm_first;
  logic rst_pulse, next_rst_pulse;
  logic clr;
  logic [P_W-1:0] mod_p;
  logic [P_W-1:0] presc_ratio;
  logic [A_W-1:0] a_cnt, next_a_cnt;
  logic presc_pulse;
  logic fb_pulse;
  logic ref_pulse;
  psyn_pfd_t state, next_state;
  logic [1:0] abw_cnt, next_abw_cnt;
  logic [1:0] abw_len;
  logic [ERR_W-1:0] err_cnt, next_err_cnt;
  logic [ERR_W-1:0] err_at;
  logic eval;
  logic good;
  logic bad;
  logic [RUN_W-1:0] run_cnt, next_run_cnt;
  logic [RUN_W-1:0] need;
  logic next_dig_lock;
  logic next_mux_out, next_mux_oe;
  logic mux_out, mux_oe;

  // Serial shift on the link clock, MSB enters first and moves up
  always_comb
  begin
    next_shreg = {shreg[WORD_W-2:0], serial_data};
  end

  // Data-only register; host keeps it still while the strobe is high
  always_ff @(posedge serial_clk)
  begin
    shreg <= next_shreg;
  end

  // Two-stage synchronisers for strobe, reference and RF pins, then edge detect
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_prev <= 3'h0;
    end
    else
    begin
      pin_meta <= {rf_in, ref_in, word_transfer_strobe};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign load = pin_sync[0] & ~pin_prev[0];
  assign ref_edge = pin_sync[1] & ~pin_prev[1];
  assign rf_edge = pin_sync[2] & ~pin_prev[2];
  assign sel = shreg[SEL_MSB:SEL_LSB];

  // Latch decode; settings move only on a strobe edge
  always_comb
  begin
    next_r_ratio = r_ratio;
    next_abw_sel = abw_sel;
    next_lock_precision_select = lock_precision_select;
    next_a_val = a_val;
    next_b_val = b_val;
    next_outsel = outsel;
    next_counter_clear_bit = counter_clear_bit;
    next_mod_sel = mod_sel;
    next_arm_first = arm_first;
    next_rst_pulse = 1'b0;
    if (load)
    begin
      if (sel == SEL_REF)
      begin
        next_r_ratio = shreg[R_MSB:R_LSB];
        next_abw_sel = shreg[ABW_MSB:ABW_LSB];
        next_lock_precision_select = shreg[PREC_BIT];
      end
      else if (sel == SEL_FB)
      begin
        next_a_val = shreg[A_MSB:A_LSB];
        next_b_val = shreg[B_MSB:B_LSB];
        next_rst_pulse = arm_first;
        next_arm_first = 1'b0;
      end
      else
      begin
        next_outsel = shreg[OUTSEL_MSB:OUTSEL_LSB];
        next_counter_clear_bit = shreg[CLR_BIT];
        next_mod_sel = shreg[MOD_MSB:MOD_LSB];
        if (sel == SEL_INIT)
        begin
          next_rst_pulse = 1'b1;
          next_arm_first = 1'b1;
        end
      end
    end
  end

  // Settings registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      r_ratio <= R_RST;
      abw_sel <= ABW_RST;
      lock_precision_select <= 1'b0;
      a_val <= A_RST;
      b_val <= B_RST;
      outsel <= OUTSEL_RST;
      counter_clear_bit <= 1'b0;
      mod_sel <= MOD_RST;
      arm_first <= 1'b0;
      rst_pulse <= 1'b0;
    end
    else
    begin
      r_ratio <= next_r_ratio;
      abw_sel <= next_abw_sel;
      lock_precision_select <= next_lock_precision_select;
      a_val <= next_a_val;
      b_val <= next_b_val;
      outsel <= next_outsel;
      counter_clear_bit <= next_counter_clear_bit;
      mod_sel <= next_mod_sel;
      arm_first <= next_arm_first;
      rst_pulse <= next_rst_pulse;
    end
  end

  assign clr = counter_clear_bit | rst_pulse;

  // Modulus choice; swallow picks P+1 until a_val prescaler cycles are done
  always_comb
  begin
    case (mod_sel)
      2'h0: mod_p = PMOD0;
      2'h1: mod_p = PMOD1;
      2'h2: mod_p = PMOD2;
      default: mod_p = PMOD3;
    endcase
    presc_ratio = mod_p + P_W'(a_cnt < a_val);
    next_a_cnt = a_cnt;
    if (clr || fb_pulse)
    begin
      next_a_cnt = '0;
    end
    else if (presc_pulse && (a_cnt < a_val))
    begin
      next_a_cnt = a_cnt + 6'h01;
    end
  end

  // Swallow count register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      a_cnt <= '0;
    end
    else
    begin
      a_cnt <= next_a_cnt;
    end
  end

  psyn_div #(.W(R_W)) u_ref_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(clr),
    .tick(ref_edge),
    .ratio(r_ratio),
    .pulse(ref_pulse)
  );

  psyn_div #(.W(P_W)) u_presc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(clr),
    .tick(rf_edge),
    .ratio(presc_ratio),
    .pulse(presc_pulse)
  );

  psyn_div #(.W(B_W)) u_main_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(clr),
    .tick(presc_pulse),
    .ratio(b_val),
    .pulse(fb_pulse)
  );

  // Detector: edges set up or down; both high starts the antibacklash reset.
  // Edges during the reset window are dropped, trading a rare miss for a simple machine.
  always_comb
  begin
    case (abw_sel)
      2'h0: abw_len = ABW_CYC0;
      2'h1: abw_len = ABW_CYC1;
      2'h2: abw_len = ABW_CYC2;
      default: abw_len = ABW_CYC3;
    endcase
    next_state = state;
    next_abw_cnt = 2'h0;
    next_err_cnt = err_cnt;
    case (state)
      PFD_IDLE:
      begin
        next_err_cnt = '0;
        if (ref_pulse && fb_pulse)
          next_state = PFD_BOTH;
        else if (ref_pulse)
          next_state = PFD_UP;
        else if (fb_pulse)
          next_state = PFD_DN;
      end
      PFD_UP:
      begin
        next_err_cnt = (err_cnt == '1) ? err_cnt : err_cnt + 8'h01;
        if (fb_pulse)
          next_state = PFD_BOTH;
      end
      PFD_DN:
      begin
        next_err_cnt = (err_cnt == '1) ? err_cnt : err_cnt + 8'h01;
        if (ref_pulse)
          next_state = PFD_BOTH;
      end
      default:
      begin
        next_abw_cnt = abw_cnt + 2'h1;
        if ((abw_cnt + 2'h1) >= abw_len)
        begin
          next_state = PFD_IDLE;
          next_abw_cnt = 2'h0;
        end
      end
    endcase
    if (clr)
    begin
      next_state = PFD_IDLE;
      next_abw_cnt = 2'h0;
      next_err_cnt = '0;
    end
  end

  // Lock judgement at each detector cycle end
  always_comb
  begin
    eval = (state != PFD_BOTH) && (next_state == PFD_BOTH);
    err_at = (state == PFD_IDLE) ? '0 : err_cnt;
    good = err_at < LOCK_CYC;
    bad = err_at >= UNLOCK_CYC;
    need = lock_precision_select ? RUN_LONG : RUN_SHORT;
    next_run_cnt = run_cnt;
    next_dig_lock = dig_lock;
    if (clr)
    begin
      next_run_cnt = '0;
      next_dig_lock = 1'b0;
    end
    else if (eval && good)
    begin
      next_run_cnt = (run_cnt >= RUN_LONG) ? run_cnt : run_cnt + 3'h1;
      if ((run_cnt + 3'h1) >= need)
        next_dig_lock = 1'b1;
    end
    else if (eval && bad)
    begin
      next_run_cnt = '0;
      next_dig_lock = 1'b0;
    end
  end

  // Status pin select; analog mode drives low only while a pump is active
  always_comb
  begin
    next_mux_out = 1'b0;
    next_mux_oe = 1'b1;
    if (outsel == OUT_DLOCK)
      next_mux_out = dig_lock;
    else if (outsel == OUT_NDIV)
      next_mux_out = fb_pulse;
    else if (outsel == OUT_HIGH)
      next_mux_out = 1'b1;
    else if (outsel == OUT_RDIV)
      next_mux_out = ref_pulse;
    else if (outsel == OUT_ALOCK)
      next_mux_oe = (state != PFD_IDLE);
    else if (outsel != OUT_LOW)
      next_mux_oe = 1'b0;
  end

  // Detector, lock and pin registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= PFD_IDLE;
      abw_cnt <= 2'h0;
      err_cnt <= '0;
      run_cnt <= '0;
      dig_lock <= 1'b0;
      mux_out <= 1'b0;
      mux_oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      abw_cnt <= next_abw_cnt;
      err_cnt <= next_err_cnt;
      run_cnt <= next_run_cnt;
      dig_lock <= next_dig_lock;
      mux_out <= next_mux_out;
      mux_oe <= next_mux_oe;
    end
  end

  assign pump_up = state[0];
  assign pump_dn = state[1];
  assign multiplexed_status_pin = mux_out;
  assign multiplexed_status_pin_oe = mux_oe;

  property p_ref_load;
    @(posedge core_clk) disable iff (!rst_n)
    (load && sel == SEL_REF) |=> r_ratio == $past(shreg[R_MSB:R_LSB]);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("reference ratio not loaded");

  property p_fb_load;
    @(posedge core_clk) disable iff (!rst_n)
    (load && sel == SEL_FB) |=> b_val == $past(shreg[B_MSB:B_LSB]) && a_val == $past(shreg[A_MSB:A_LSB]);
  endproperty
  a_fb_load: assert property (p_fb_load) else $error("feedback fields not loaded");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
    !load |=> $stable(r_ratio) && $stable(b_val) && $stable(outsel) && $stable(mod_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("setting changed without strobe");

  property p_init;
    @(posedge core_clk) disable iff (!rst_n)
    (load && sel == SEL_INIT) |=> rst_pulse ##1 !fb_pulse && !ref_pulse;
  endproperty
  a_init: assert property (p_init) else $error("init load gave no counter reset");

  property p_fb_rearm;
    @(posedge core_clk) disable iff (!rst_n)
    (load && sel == SEL_FB) |=> rst_pulse == $past(arm_first) && !arm_first;
  endproperty
  a_fb_rearm: assert property (p_fb_rearm) else $error("feedback load reset pulse wrong after init");

  property p_clear;
    @(posedge core_clk) disable iff (!rst_n)
    counter_clear_bit ##1 counter_clear_bit |-> !fb_pulse && !ref_pulse && a_cnt == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("counters ran while cleared");

  property p_lock_short;
    @(posedge core_clk) disable iff (!rst_n)
    ($rose(dig_lock) && !$past(lock_precision_select)) |-> run_cnt >= RUN_SHORT;
  endproperty
  a_lock_short: assert property (p_lock_short) else $error("lock set before three good cycles");

  property p_lock_long;
    @(posedge core_clk) disable iff (!rst_n)
    ($rose(dig_lock) && $past(lock_precision_select)) |-> run_cnt >= RUN_LONG;
  endproperty
  a_lock_long: assert property (p_lock_long) else $error("lock set before five good cycles");

  property p_unlock;
    @(posedge core_clk) disable iff (!rst_n)
    (eval && bad) |=> !dig_lock;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock kept after large error");

  property p_mux_dlock;
    @(posedge core_clk) disable iff (!rst_n)
    outsel == OUT_DLOCK |=> multiplexed_status_pin == $past(dig_lock) && multiplexed_status_pin_oe;
  endproperty
  a_mux_dlock: assert property (p_mux_dlock) else $error("status pin not showing lock");

  property p_mux_alock;
    @(posedge core_clk) disable iff (!rst_n)
    outsel == OUT_ALOCK |=> !multiplexed_status_pin && multiplexed_status_pin_oe == ($past(state) != PFD_IDLE);
  endproperty
  a_mux_alock: assert property (p_mux_alock) else $error("analog lock pin wrong");

  property p_pfd_release;
    @(posedge core_clk) disable iff (!rst_n)
    (state != PFD_BOTH) ##1 (state == PFD_BOTH) |-> ##[1:3] state == PFD_IDLE;
  endproperty
  a_pfd_release: assert property (p_pfd_release) else $error("detector reset too long");

endmodule // psyn_core

// file: verif/psyn_host.sv
// Purpose: Host model that drives the three-wire serial programming link.
// Assumes: link clock period of 32 ns, running only inside a frame.
// Notes: Data line shows the inverse of the last bit once released.
`timescale 1ns/100ps
module psyn_host (
  output logic serial_clk,
  output logic serial_data,
  output logic word_transfer_strobe
);
  // Link idles with clock parked low
  initial
  begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    word_transfer_strobe = 1'b0;
  end

  // One frame, MSB first, then an optional transfer strobe
  task automatic send_word(input logic [23:0] w, input bit load);
    for (int i = 23; i >= 0; i--)
    begin
      serial_data = w[i];
      #16 serial_clk = 1'b1;
      #16 serial_clk = 1'b0;
    end
    serial_data = ~w[0]; // No stale bit after release
    if (load)
    begin
      #40 word_transfer_strobe = 1'b1;
      #500 word_transfer_strobe = 1'b0; // Long enough for the core's synchroniser
    end
    #300;
  endtask
endmodule // psyn_host

// file: verif/psyn_core_test.sv
// Purpose: Self-checking bench for the synthesizer digital core.
// Assumes: rst_n, ref_in and rf_in change on the falling core clock edge; the host drives the serial link on its own 16 ns steps.
// Notes: Status pin carries a pull-up; divider inputs toggle every two cycles.
`timescale 1ns/100ps
module psyn_core_test;
  import psyn_pkg::*;
  typedef struct {logic [23:0] w; logic pin; logic oe;} psyn_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ref_in = 1'b0;
  logic rf_in = 1'b0;
  logic serial_clk, serial_data, word_transfer_strobe;
  logic pump_up, pump_dn, dig_lock, pin, pin_oe, pin_wire;
  int failures = 0;
  int num_checks = 0;
  int hi_cnt = 0, both_cnt = 0, low_cnt = 0, dn_cnt = 0;
  int cfg_prec[3] = '{0, 1, 0};
  int cfg_abw[3] = '{0, 2, 3};
  int cfg_wid[3] = '{2, 3, 2};
  int cfg_need[3] = '{3, 5, 3};
  psyn_row_t rows[8];

  always #50 core_clk = ~core_clk;
  assign pin_wire = pin_oe ? pin : 1'b1; // Pull-up when released

  psyn_core i_psyn_core (.core_clk(core_clk), .rst_n(rst_n), .serial_clk(serial_clk),
    .serial_data(serial_data), .word_transfer_strobe(word_transfer_strobe), .ref_in(ref_in),
    .rf_in(rf_in), .pump_up(pump_up), .pump_dn(pump_dn), .dig_lock(dig_lock),
    .multiplexed_status_pin(pin), .multiplexed_status_pin_oe(pin_oe));
  psyn_host i_psyn_host (.serial_clk(serial_clk), .serial_data(serial_data),
    .word_transfer_strobe(word_transfer_strobe));

  // Running tallies, so tests compare differences and never share a writer
  always @(posedge core_clk)
  begin
    hi_cnt <= hi_cnt + int'(pin_oe === 1'b1 && pin === 1'b1);
    both_cnt <= both_cnt + int'(pump_up === 1'b1 && pump_dn === 1'b1);
    low_cnt <= low_cnt + int'(pin_wire === 1'b0);
    dn_cnt <= dn_cnt + int'(pump_dn === 1'b1 && pump_up === 1'b0);
  end

  task automatic check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_cnt(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp)
    begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Word builders from the package field positions
  function automatic logic [23:0] fw(input logic [1:0] m, input logic [2:0] o, input logic c,
    input logic [1:0] s);
    logic [23:0] w;
    w = 24'h000000;
    w[MOD_MSB:MOD_LSB] = m;
    w[OUTSEL_MSB:OUTSEL_LSB] = o;
    w[CLR_BIT] = c;
    w[SEL_MSB:SEL_LSB] = s;
    return w;
  endfunction

  function automatic logic [23:0] rw(input logic [13:0] r, input logic [1:0] ab, input logic prec);
    logic [23:0] w;
    w = 24'h000000;
    w[R_MSB:R_LSB] = r;
    w[ABW_MSB:ABW_LSB] = ab;
    w[PREC_BIT] = prec;
    return w;
  endfunction

  function automatic logic [23:0] nw(input logic [12:0] b, input logic [5:0] a);
    logic [23:0] w;
    w = 24'h000000;
    w[B_MSB:B_LSB] = b;
    w[A_MSB:A_LSB] = a;
    w[SEL_MSB:SEL_LSB] = SEL_FB;
    return w;
  endfunction

  // Load one word and let the synchronised strobe land
  task automatic put(input logic [23:0] w);
    i_psyn_host.send_word(w, 1'b1);
    repeat (3) @(negedge core_clk);
  endtask

  // n rising edges on the chosen inputs, four core cycles each
  task automatic edges(input bit r, input bit f, input int n);
    repeat (n)
    begin
      @(negedge core_clk);
      ref_in = r;
      rf_in = f;
      repeat (2) @(negedge core_clk);
      ref_in = 1'b0;
      rf_in = 1'b0;
      @(negedge core_clk);
    end
    repeat (8) @(negedge core_clk);
  endtask

  // Hang guard, well beyond the expected 26k cycles
  initial
  begin
    #8000000;
    failures++;
    $display("[FAIL] run expected finish seen timeout");
    print_verdict();
  end

  // Main sequence
  initial
  begin
    int h, p, n, b0, l0, d0;
    rows[0] = '{fw(2'h0, OUT_HIGH, 1'b0, SEL_FUNC), 1'b1, 1'b1};
    rows[1] = '{fw(2'h0, OUT_LOW, 1'b0, SEL_REF), 1'b1, 1'b1};
    rows[2] = '{nw(13'h001f, 6'h1c), 1'b1, 1'b1};
    rows[3] = '{fw(2'h0, OUT_LOW, 1'b0, SEL_FUNC), 1'b0, 1'b1};
    rows[4] = '{fw(2'h0, OUT_TRI, 1'b0, SEL_INIT), 1'b0, 1'b0};
    rows[5] = '{fw(2'h0, OUT_HIGH, 1'b0, SEL_INIT), 1'b1, 1'b1};
    rows[6] = '{fw(2'h0, 3'h6, 1'b0, SEL_FUNC), 1'b0, 1'b0};
    rows[7] = '{fw(2'h0, OUT_DLOCK, 1'b0, SEL_FUNC), 1'b0, 1'b1};
    repeat (21) @(negedge core_clk);
    check_bit("reset pump_up", 1'b0, pump_up);
    check_bit("reset dig_lock", 1'b0, dig_lock);
    check_bit("reset pin_oe", 1'b0, pin_oe);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    $display("test reset done");
    // Routing and output select table
    foreach (rows[i])
    begin
      put(rows[i].w);
      check_bit("status pin", rows[i].pin, pin);
      check_bit("status oe", rows[i].oe, pin_oe);
    end
    $display("test routing done");
    i_psyn_host.send_word(fw(2'h0, OUT_HIGH, 1'b0, SEL_FUNC), 1'b0);
    repeat (5) @(negedge core_clk);
    check_bit("pin after shift only", 1'b0, pin);
    $display("test shift only done");
    // Reference divider by 5, held first by the clear bit
    put(rw(14'h0005, 2'h0, 1'b0));
    put(fw(2'h0, OUT_RDIV, 1'b1, SEL_FUNC));
    h = hi_cnt;
    edges(1'b1, 1'b0, 6);
    check_cnt("ref pulses in clear", 0, hi_cnt - h);
    put(fw(2'h0, OUT_RDIV, 1'b0, SEL_FUNC));
    h = hi_cnt;
    edges(1'b1, 1'b0, 4);
    check_cnt("ref pulses at 4", 0, hi_cnt - h);
    edges(1'b1, 1'b0, 1);
    check_cnt("ref pulses at 5", 1, hi_cnt - h);
    $display("test ref divider done");
    // Feedback ratio for every modulus, B = P-1 keeps the minimum ratio
    for (int m = 0; m < 4; m++)
    begin
      p = 8 << m;
      n = (p - 1) * p + 2;
      put(nw(13'(p - 1), 6'h02));
      put(fw(2'(m), OUT_NDIV, 1'b1, SEL_FUNC));
      put(fw(2'(m), OUT_NDIV, 1'b0, SEL_FUNC));
      h = hi_cnt;
      edges(1'b0, 1'b1, n - 1);
      check_cnt("fb pulses at N-1", 0, hi_cnt - h);
      edges(1'b0, 1'b1, 1);
      check_cnt("fb pulses at N", 1, hi_cnt - h);
    end
    $display("test feedback divider done");
    // Lock run per precision and width, matched R = N = 56
    for (int k = 0; k < 3; k++)
    begin
      put(rw(14'h0038, 2'(cfg_abw[k]), 1'(cfg_prec[k])));
      put(nw(13'h0007, 6'h00));
      put(fw(2'h0, OUT_ALOCK, 1'b1, SEL_FUNC));
      put(fw(2'h0, OUT_ALOCK, 1'b0, SEL_FUNC));
      for (int g = 1; g <= cfg_need[k] + 1; g++)
      begin
        b0 = both_cnt;
        l0 = low_cnt;
        edges(1'b1, 1'b1, 56);
        check_bit("dig_lock", 1'(g >= cfg_need[k]), dig_lock);
        check_cnt("both high cycles", cfg_wid[k], both_cnt - b0);
        // Up pump leads by one cycle: the feedback path has one more divider stage
        check_cnt("analog lock low", cfg_wid[k] + 1, low_cnt - l0);
      end
      d0 = dn_cnt;
      edges(1'b0, 1'b1, 1);
      edges(1'b1, 1'b1, 56);
      check_bit("dig_lock after slip", 1'b0, dig_lock);
      check_bit("down leads", 1'b1, 1'(dn_cnt > d0));
    end
    $display("test lock done");
    // Reset in mid-run drops the detector and the pin drive
    put(fw(2'h0, OUT_HIGH, 1'b0, SEL_FUNC));
    edges(1'b1, 1'b0, 56);
    check_bit("pump_up before reset", 1'b1, pump_up);
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    check_bit("pump_up in reset", 1'b0, pump_up);
    check_bit("pin_oe in reset", 1'b0, pin_oe);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    $display("test mid reset done");
    print_verdict();
  end
endmodule // psyn_core_test
